// ==== include/geom_pkg.sv ====
// Purpose: Shared constants for the geometry, recalibrate and identify block.
// Assumes: One 125 MHz clock, task-file inputs synchronous to it.
// Notes: Command codes and word numbers are held here once.
//
// Functional notes
// RQ1: Word 83 reads bit15 zero, bit14 one, bit0 microcode download supported.
// RQ2: Word 84 reads bit15 zero, bit14 one, remaining bits zero.
// RQ3: Word 85 carries one enable flag per feature, bit15 identify DMA to bit0 SMART.
// RQ4: Words 86 and 87 read bit15 zero, bit14 one; word 86 bit0 microcode.
// RQ5: Word 88 flags selected Ultra DMA mode in bits 10-8, support in 2-0.
// RQ6: Word 128 gives security level in bit8, expired..supported in bits 4-0.
// RQ7: Drive always translates a host chosen logical geometry onto physical sectors.
// RQ8: Host keeps logical heads times sectors within the physical sector count.
// RQ9: Initialize takes sectors from sector count, max head from drive/head, computes cylinders.
// RQ10: Initialize sets busy, stores parameters, clears busy, then raises interrupt.
// RQ11: Host writes head count minus one, and the true sectors per track.
// RQ12: Geometry values are never checked when accepted.
// RQ13: Logical cylinder count above 65535 is clamped to 65535.
// RQ14: Recalibrate sets busy and issues a seek to cylinder zero.
// RQ15: After seek completes: update status, clear busy, raise interrupt, in order.
// RQ16: Failure to reach cylinder zero sets status error and error track-zero bits.
package geom_pkg;
    localparam int TOTAL_W = 32;
    localparam int DIVISOR_W = 13;
    localparam int CNT_W = 6;
    localparam logic [7:0] CMD_INIT_PARAMS = 8'h91;
    localparam logic [7:0] CMD_RECAL = 8'h10;
    localparam logic [15:0] CYL_LIMIT = 16'hFFFF;
    localparam logic [15:0] SEEK_HOME_CYL = 16'h0000;
    localparam logic [7:0] WORD_CMD_SUP = 8'h53;
    localparam logic [7:0] WORD_EXT_SUP = 8'h54;
    localparam logic [7:0] WORD_CMD_EN = 8'h55;
    localparam logic [7:0] WORD_SETS_EN = 8'h56;
    localparam logic [7:0] WORD_EXT_EN = 8'h57;
    localparam logic [7:0] WORD_UDMA = 8'h58;
    localparam logic [7:0] WORD_SECURITY = 8'h80;
    localparam logic [15:0] WORD_VALID_MARK = 16'h4000;
    localparam int UDMA_SEL_LSB = 8;
    localparam int SEC_LEVEL_BIT = 8;
    localparam int ST_BUSY = 7;
    localparam int ST_READY = 6;
    localparam int ST_ERR = 0;
    localparam int ER_TRK0 = 1;
    localparam logic [7:0] STATUS_RESET = 8'h40;
    localparam logic [7:0] ERROR_RESET = 8'h00;
    localparam logic [7:0] SECT_RESET = 8'h00;
    localparam logic [3:0] HEAD_RESET = 4'h0;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_STORE = 3'b001,
        ST_CALC = 3'b011,
        ST_RELEASE = 3'b010,
        ST_NOTIFY = 3'b110,
        ST_SEEK = 3'b100
    } seq_type;
endpackage

// ==== include/geom_link_if.sv ====
// Purpose: Carries divider and identify traffic between the block's modules.
// Assumes: All members run on core_clk.
// Notes: The core owns requests, the helpers own answers.
`timescale 1ns/1ps
interface geom_link_if;
    import geom_pkg::*;
    logic div_start;
    logic [TOTAL_W-1:0] div_total;
    logic [DIVISOR_W-1:0] div_divisor;
    logic div_done;
    logic [15:0] div_cyl;
    logic [7:0] ident_addr;
    logic [15:0] ident_data;
    logic microcode_sup;
    logic microcode_en;
    logic [15:0] feature_en;
    logic [2:0] udma_sel;
    logic [2:0] udma_sup;
    logic sec_level;
    logic [4:0] sec_flags;

    modport core (output div_start, div_total, div_divisor, ident_addr, microcode_sup, microcode_en,
        feature_en, udma_sel, udma_sup, sec_level, sec_flags, input div_done, div_cyl, ident_data);
    modport div (input div_start, div_total, div_divisor, output div_done, div_cyl);
    modport ident (input ident_addr, microcode_sup, microcode_en, feature_en, udma_sel, udma_sup,
        sec_level, sec_flags, output ident_data);
endinterface

// ==== core/cyl_divider.sv ====
// Purpose: Divides physical sectors by logical sectors per cylinder.
// Assumes: A start pulse arrives only while idle.
// Notes: Restoring divider, one quotient bit per clock.
`timescale 1ns/1ps
module cyl_divider (
    input wire logic core_clk,
    input wire logic nrst,
    geom_link_if.div lnk
);
    import geom_pkg::*;

    logic [TOTAL_W-1:0] rem, next_rem;
    logic [TOTAL_W-1:0] quo, next_quo;
    logic [CNT_W-1:0] cnt, next_cnt;
    logic running, next_running;
    logic done, next_done;
    logic [15:0] cyl, next_cyl;
    logic [TOTAL_W-1:0] trial;

    if ((2 ** CNT_W) <= TOTAL_W) begin : g_bad_cnt
        $error("CNT_W too narrow for TOTAL_W.");
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_rem = rem;
        next_quo = quo;
        next_cnt = cnt;
        next_running = running;
        next_done = 1'b0;
        next_cyl = cyl;
        trial = {rem[TOTAL_W-2:0], quo[TOTAL_W-1]};
        if (lnk.div_start) begin
            next_rem = '0;
            next_quo = lnk.div_total;
            next_cnt = CNT_W'(TOTAL_W);
            next_running = 1'b1;
        end else if (running) begin
            next_quo = {quo[TOTAL_W-2:0], 1'b0};
            if (trial >= TOTAL_W'(lnk.div_divisor)) begin
                next_rem = trial - TOTAL_W'(lnk.div_divisor);
                next_quo[0] = 1'b1;
            end else begin
                next_rem = trial;
            end
            next_cnt = cnt - 1'b1;
            if (cnt == CNT_W'(1)) begin
                next_running = 1'b0;
                next_done = 1'b1;
                if (next_quo > TOTAL_W'(CYL_LIMIT)) begin
                    next_cyl = CYL_LIMIT; // RQ13
                end else begin
                    next_cyl = next_quo[15:0];
                end
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rem <= '0;
            quo <= '0;
            cnt <= '0;
            running <= 1'b0;
            done <= 1'b0;
            cyl <= '0;
        end else begin
            rem <= next_rem;
            quo <= next_quo;
            cnt <= next_cnt;
            running <= next_running;
            done <= next_done;
            cyl <= next_cyl;
        end
    end

    assign lnk.div_done = done;
    assign lnk.div_cyl = cyl;
endmodule

// ==== core/identify_words.sv ====
// Purpose: Builds the upper identify words for a word address.
// Assumes: Address is stable for one clock before data is used.
// Notes: Words not held here read as zero.
`timescale 1ns/1ps
module identify_words (
    input wire logic core_clk,
    input wire logic nrst,
    geom_link_if.ident lnk
);
    import geom_pkg::*;

    logic [15:0] data, next_data;

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_data = '0;
        unique case (lnk.ident_addr)
            WORD_CMD_SUP: next_data = WORD_VALID_MARK | 16'(lnk.microcode_sup); // RQ1
            WORD_EXT_SUP: next_data = WORD_VALID_MARK; // RQ2
            WORD_CMD_EN: next_data = lnk.feature_en; // RQ3
            WORD_SETS_EN: next_data = WORD_VALID_MARK | 16'(lnk.microcode_en); // RQ4
            WORD_EXT_EN: next_data = WORD_VALID_MARK; // RQ4
            WORD_UDMA: next_data = (16'(lnk.udma_sel) << UDMA_SEL_LSB) | 16'(lnk.udma_sup); // RQ5
            WORD_SECURITY: next_data = (16'(lnk.sec_level) << SEC_LEVEL_BIT) | 16'(lnk.sec_flags); // RQ6
            default: next_data = '0;
        endcase
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            data <= '0;
        end else begin
            data <= next_data;
        end
    end

    assign lnk.ident_data = data;
endmodule

// ==== core/ata_geometry_recal_identify.sv ====
// Purpose: Executes initialize-parameters and recalibrate, and serves upper identify words.
// Assumes: Task-file inputs are synchronous to core_clk; a seek engine answers seek_req.
// Notes: Commands arriving while busy are ignored.
`timescale 1ns/1ps
module ata_geometry_recal_identify #(
    parameter logic [geom_pkg::TOTAL_W-1:0] PHYS_SECTORS = 32'h0100_0000
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_code,
    input wire logic [7:0] sector_count,
    input wire logic [3:0] max_head,
    output logic busy,
    output logic irq,
    output logic [7:0] status,
    output logic [7:0] error,
    output logic [7:0] logical_sectors,
    output logic [3:0] logical_max_head,
    output logic [15:0] logical_cylinders,
    output logic seek_req,
    output logic [15:0] seek_cyl,
    input wire logic seek_done,
    input wire logic seek_fail,
    input wire logic [7:0] ident_addr,
    output logic [15:0] ident_data,
    input wire logic microcode_sup,
    input wire logic microcode_en,
    input wire logic [15:0] feature_en,
    input wire logic [2:0] udma_sel,
    input wire logic [2:0] udma_sup,
    input wire logic sec_level,
    input wire logic [4:0] sec_flags
);
    import geom_pkg::*;

    if (PHYS_SECTORS == '0) begin : g_bad_phys
        $error("PHYS_SECTORS must be nonzero.");
    end

    geom_link_if lnk();

    seq_type state, next_state;
    logic next_busy;
    logic next_irq;
    logic [7:0] next_status;
    logic [7:0] next_error;
    logic [7:0] next_sectors;
    logic [3:0] next_head;
    logic [15:0] next_cylinders;
    logic next_seek_req;
    logic next_div_start;
    logic div_start;

    ////////////////////////////////////////////////////////////////////////////////
    // Helper wiring to the identify and divider modules.
    assign lnk.ident_addr = ident_addr;
    assign lnk.microcode_sup = microcode_sup;
    assign lnk.microcode_en = microcode_en;
    assign lnk.feature_en = feature_en;
    assign lnk.udma_sel = udma_sel;
    assign lnk.udma_sup = udma_sup;
    assign lnk.sec_level = sec_level;
    assign lnk.sec_flags = sec_flags;
    assign ident_data = lnk.ident_data;

    assign lnk.div_start = div_start;
    assign lnk.div_total = PHYS_SECTORS; // RQ7
    // Sectors per cylinder is heads times sectors; heads are max head plus one.
    assign lnk.div_divisor = (DIVISOR_W'(logical_max_head) + DIVISOR_W'(1)) * DIVISOR_W'(logical_sectors); // RQ9

    assign seek_cyl = SEEK_HOME_CYL; // RQ14

    identify_words u_ident (
        .core_clk(core_clk),
        .nrst(nrst),
        .lnk(lnk.ident)
    );

    cyl_divider u_div (
        .core_clk(core_clk),
        .nrst(nrst),
        .lnk(lnk.div)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Command sequencer.
    always_comb begin
        next_state = state;
        next_busy = busy;
        next_irq = 1'b0;
        next_status = status;
        next_error = error;
        next_sectors = logical_sectors;
        next_head = logical_max_head;
        next_cylinders = logical_cylinders;
        next_seek_req = 1'b0;
        next_div_start = 1'b0;
        unique case (state)
            ST_IDLE: begin
                if (cmd_valid && cmd_code == CMD_INIT_PARAMS) begin
                    next_busy = 1'b1; // RQ10
                    next_status[ST_BUSY] = 1'b1;
                    next_status[ST_ERR] = 1'b0;
                    next_error = ERROR_RESET;
                    next_state = ST_STORE;
                end else if (cmd_valid && cmd_code == CMD_RECAL) begin
                    next_busy = 1'b1; // RQ14
                    next_status[ST_BUSY] = 1'b1;
                    next_status[ST_ERR] = 1'b0;
                    next_error = ERROR_RESET;
                    next_seek_req = 1'b1; // RQ14
                    next_state = ST_SEEK;
                end
            end
            ST_STORE: begin
                // Values are stored as given, with no range check.
                next_sectors = sector_count; // RQ9 RQ12
                next_head = max_head; // RQ9 RQ12
                next_div_start = 1'b1;
                next_state = ST_CALC;
            end
            ST_CALC: begin
                if (lnk.div_done) begin
                    next_cylinders = lnk.div_cyl; // RQ13
                    next_state = ST_RELEASE;
                end
            end
            ST_SEEK: begin
                if (seek_done) begin
                    next_status[ST_ERR] = seek_fail; // RQ15 RQ16
                    next_error[ER_TRK0] = seek_fail; // RQ16
                    next_state = ST_RELEASE;
                end
            end
            ST_RELEASE: begin
                next_busy = 1'b0; // RQ10 RQ15
                next_status[ST_BUSY] = 1'b0;
                next_state = ST_NOTIFY;
            end
            ST_NOTIFY: begin
                next_irq = 1'b1; // RQ10 RQ15
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
                next_busy = 1'b0;
                next_status[ST_BUSY] = 1'b0;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state <= ST_IDLE;
            busy <= 1'b0;
            irq <= 1'b0;
            status <= STATUS_RESET;
            error <= ERROR_RESET;
            logical_sectors <= SECT_RESET;
            logical_max_head <= HEAD_RESET;
            logical_cylinders <= '0;
            seek_req <= 1'b0;
            div_start <= 1'b0;
        end else begin
            state <= next_state;
            busy <= next_busy;
            irq <= next_irq;
            status <= next_status;
            error <= next_error;
            logical_sectors <= next_sectors;
            logical_max_head <= next_head;
            logical_cylinders <= next_cylinders;
            seek_req <= next_seek_req;
            div_start <= next_div_start;
        end
    end
endmodule

// ==== tb/geom_monitor.sv ====
// Purpose: Watches command timing, status and seek requests at the block's ports.
// Assumes: All ports are synchronous to core_clk; nrst is asynchronous, active low.
// Notes: Bound to the top module at the foot of this file.
`timescale 1ns/1ps
module geom_monitor
    import geom_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_code,
    input wire logic busy,
    input wire logic irq,
    input wire logic [7:0] status,
    input wire logic [7:0] error,
    input wire logic seek_req,
    input wire logic [15:0] seek_cyl,
    input wire logic seek_done,
    input wire logic seek_fail
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);

    init_timing_a: assert property (cmd_valid && !busy && !$past(busy) && cmd_code == CMD_INIT_PARAMS
        |=> busy ##35 busy ##1 !busy && !irq ##1 irq) else $error("init busy or irq timing wrong");
    recal_seek_a: assert property (cmd_valid && !busy && !$past(busy) && cmd_code == CMD_RECAL
        |=> busy && seek_req && seek_cyl == SEEK_HOME_CYL) else $error("recal did not start a home seek");
    seek_end_a: assert property (seek_done && busy |=> busy && status[ST_ERR] == $past(seek_fail)
        && error[ER_TRK0] == $past(seek_fail) ##1 !busy && !irq ##1 irq) else $error("seek end order wrong");
    status_busy_a: assert property (status[ST_BUSY] == busy && status[ST_READY])
        else $error("status busy or ready bit wrong");
    irq_pulse_a: assert property (irq |=> !irq && busy == $past(cmd_valid
        && (cmd_code == CMD_INIT_PARAMS || cmd_code == CMD_RECAL))) else $error("irq not a single pulse");
    irq_cause_a: assert property ($rose(irq) |-> $past(busy, 2) && !$past(busy))
        else $error("irq without busy release before it");
    busy_refuse_a: assert property (busy && cmd_valid |=> !seek_req) else $error("command taken while busy");
    code_ignore_a: assert property (cmd_valid && !busy && cmd_code != CMD_INIT_PARAMS
        && cmd_code != CMD_RECAL |=> !busy) else $error("unknown code started work");
endmodule

bind ata_geometry_recal_identify geom_monitor mon_u (.core_clk(core_clk), .nrst(nrst), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .busy(busy), .irq(irq), .status(status), .error(error), .seek_req(seek_req),
    .seek_cyl(seek_cyl), .seek_done(seek_done), .seek_fail(seek_fail));

// ==== tb/seek_model.sv ====
// Purpose: Seek engine that answers a home seek after a set delay.
// Assumes: delay and fail_mode are held steady by the bench during a seek.
// Notes: Outside the done pulse the fail line shows the opposite level.
`timescale 1ns/1ps
module seek_model (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic seek_req,
    input wire logic [7:0] delay,
    input wire logic fail_mode,
    output logic seek_done,
    output logic seek_fail
);
    logic [7:0] cnt;
    logic run;
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cnt <= 8'h00;
            run <= 1'b0;
            seek_done <= 1'b0;
            seek_fail <= 1'b0;
        end else begin
            seek_done <= 1'b0;
            seek_fail <= ~fail_mode;
            if (seek_req) begin
                run <= 1'b1;
                cnt <= delay;
            end else if (run && cnt == 8'h00) begin
                run <= 1'b0;
                seek_done <= 1'b1;
                seek_fail <= fail_mode;
            end else if (run) begin
                cnt <= cnt - 8'h01;
            end
        end
    end
endmodule

// ==== tb/tb_ata_geometry_recal_identify.sv ====
// Purpose: Runs geometry, recalibrate and identify sequences against expected values.
// Assumes: Inputs change at the falling edge of core_clk.
// Notes: A small physical sector count keeps some cylinder results below the 65535 clamp.
`timescale 1ns/1ps
module tb_ata_geometry_recal_identify;
    import geom_pkg::*;
    localparam logic [31:0] PHYS = 32'h0003_0D40;
    logic core_clk, nrst, cmd_valid, busy, irq, seek_req, seek_done, seek_fail, fail_mode;
    logic microcode_sup, microcode_en, sec_level;
    logic [7:0] cmd_code, sector_count, status, error, logical_sectors, ident_addr, delay;
    logic [3:0] max_head, logical_max_head;
    logic [15:0] logical_cylinders, seek_cyl, ident_data, feature_en;
    logic [2:0] udma_sel, udma_sup;
    logic [4:0] sec_flags;
    int bad_count = 0, n_compared = 0, seek_n = 0;
    logic [7:0] words [8] = '{WORD_CMD_SUP, WORD_EXT_SUP, WORD_CMD_EN, WORD_SETS_EN, WORD_EXT_EN, WORD_UDMA,
        WORD_SECURITY, 8'h7F};
    ata_geometry_recal_identify #(.PHYS_SECTORS(PHYS)) dut_u (.core_clk(core_clk), .nrst(nrst),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code), .sector_count(sector_count), .max_head(max_head), .busy(busy),
        .irq(irq), .status(status), .error(error), .logical_sectors(logical_sectors),
        .logical_max_head(logical_max_head), .logical_cylinders(logical_cylinders), .seek_req(seek_req),
        .seek_cyl(seek_cyl), .seek_done(seek_done), .seek_fail(seek_fail), .ident_addr(ident_addr),
        .ident_data(ident_data), .microcode_sup(microcode_sup), .microcode_en(microcode_en),
        .feature_en(feature_en), .udma_sel(udma_sel), .udma_sup(udma_sup), .sec_level(sec_level),
        .sec_flags(sec_flags));
    seek_model seek_u (.core_clk(core_clk), .nrst(nrst), .seek_req(seek_req), .delay(delay),
        .fail_mode(fail_mode), .seek_done(seek_done), .seek_fail(seek_fail));
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    always @(posedge core_clk) if (seek_req === 1'b1) seek_n++;
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("Compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic pulse(input logic [7:0] code, input logic [7:0] sc, input logic [3:0] mh);
        @(negedge core_clk);
        cmd_valid = 1'b1;
        cmd_code = code;
        sector_count = sc;
        max_head = mh;
        @(negedge core_clk);
        cmd_valid = 1'b0;
    endtask
    task automatic wait_irq();
        int i;
        i = 0;
        while (irq !== 1'b1 && i < 300) begin
            @(negedge core_clk);
            i++;
        end
        check(16'(i < 300), 16'h0001);
    endtask
    function automatic logic [15:0] ident_exp(input logic [7:0] a);
        case (a)
            WORD_CMD_SUP, WORD_SETS_EN: return {15'h2000, a == WORD_CMD_SUP ? microcode_sup : microcode_en};
            WORD_EXT_SUP, WORD_EXT_EN: return 16'h4000;
            WORD_CMD_EN: return feature_en;
            WORD_UDMA: return {5'h00, udma_sel, 5'h00, udma_sup};
            WORD_SECURITY: return {7'h00, sec_level, 3'h0, sec_flags};
            default: return 16'h0000;
        endcase
    endfunction
    function automatic logic [15:0] cyl_exp(input logic [7:0] sc, input logic [3:0] mh);
        logic [31:0] q;
        if (sc == 8'h00) return 16'hFFFF;
        q = PHYS / ((32'(mh) + 32'h0000_0001) * 32'(sc));
        return q > 32'h0000_FFFF ? 16'hFFFF : q[15:0];
    endfunction
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #100000;
        bad_count++;
        test_done();
    end
    initial begin
        logic [7:0] scs [3] = '{8'h11, 8'h01, 8'h00};
        logic [3:0] mhs [3] = '{4'h4, 4'h0, 4'hF};
        {nrst, cmd_valid, cmd_code, sector_count, max_head, ident_addr, fail_mode} = '0;
        {microcode_sup, microcode_en, feature_en, udma_sel, udma_sup, sec_level, sec_flags} = '0;
        delay = 8'h06;
        repeat (8) @(posedge core_clk);
        @(negedge core_clk);
        nrst = 1'b1;
        check(status, 16'(STATUS_RESET));
        check({error, 7'h00, busy}, 16'h0000);
        check(logical_cylinders, 16'h0000);
        for (int p = 0; p < 2; p++) begin
            {microcode_sup, microcode_en, feature_en} = p ? 18'h2_5AC3 : 18'h0_A53C;
            {udma_sel, udma_sup, sec_level, sec_flags} = p ? 12'h214 : 12'h4F9;
            for (int k = 0; k < 8; k++) begin
                @(negedge core_clk);
                ident_addr = words[k];
                @(negedge core_clk);
                check(ident_data, ident_exp(words[k]));
            end
        end
        for (int g = 0; g < 3; g++) begin
            pulse(CMD_INIT_PARAMS, scs[g], mhs[g]);
            if (g == 0) pulse(CMD_RECAL, scs[g], mhs[g]);
            wait_irq();
            check(logical_sectors, scs[g]);
            check(logical_max_head, mhs[g]);
            check(logical_cylinders, cyl_exp(scs[g], mhs[g]));
        end
        check(16'(seek_n), 16'h0000);
        fail_mode = 1'b1;
        pulse(CMD_RECAL, 8'h00, 4'h0);
        wait_irq();
        check({status, error}, 16'h4102);
        fail_mode = 1'b0;
        delay = 8'h20;
        pulse(CMD_RECAL, 8'h00, 4'h0);
        wait_irq();
        check({status, error}, 16'h4000);
        check(16'(seek_n), 16'h0002);
        pulse(8'hEC, 8'h00, 4'h0);
        @(negedge core_clk);
        check(busy, 1'b0);
        test_done();
    end
endmodule
